//--- logic/dcs_defs.svh
// Offsets, field positions, reset values and bus addresses of the switch bank
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
`define DCS_WR_ADDR 8'h8C
`define DCS_RD_ADDR 8'h8D
`define DCS_SAD_DUTY 8'h00
`define DCS_SAD_MOIRE 8'h02
`define DCS_SAD_PREF 8'h03
`define DCS_SAD_PDRV 8'h07
`define DCS_SAD_EW 8'h08
`define DCS_SAD_DYN 8'h15
`define DCS_SAD_LOOP 8'h16
`define DCS_SAD_OUT 8'h17
`define DCS_REG_RST 8'h00
`define DCS_B_HI 7
`define DCS_B_LOCKEN 0
`define DCS_B_INHEN 1
`define DCS_B_PUMP 2
`define DCS_B_MOIMODE 3
`define DCS_B_DETCLR 4
`define DCS_B_VSEL 5
`define DCS_B_VAUTO 6
`define DCS_B_ALMCLR 7
`define DCS_B_BLANK 0
`define DCS_B_VERTICAL_OUTPUT_ENABLE 1
`define DCS_B_DRVEN 2
`define DCS_B_EDGE 3
`define DCS_B_TEST_LO 4
`define DCS_BIT_LAST 4'h8
`endif

//--- logic/dcs_pkg.sv
// Types of the deflection switch bank
package dcs_pkg;
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_ADDR = 7'h02,
      S_AACK = 7'h04,
      S_WR = 7'h08,
      S_WACK = 7'h10,
      S_RD = 7'h20,
      S_RACK = 7'h40
   } dcs_fsm_t;

   typedef struct packed {
      logic supply_ok;
      logic vsync;
      logic csync;
      logic extr;
      logic vertical_input_polarity;
      logic cpol;
      logic overvoltage_in;
      logic vertical_amplitude_locked_n_n;
      logic horizontal_loop_locked_n_n;
      logic vdisch;
      logic flyback;
      logic hdrive;
      logic bdrive;
   } dcs_ana_t;

   typedef struct packed {
      logic [7:0] duty;
      logic [7:0] moire;
      logic [7:0] pref;
      logic [7:0] pdrv;
      logic [7:0] ew;
      logic [7:0] dyn;
      logic [7:0] loop;
      logic [7:0] outc;
   } dcs_regs_t;

   typedef struct packed {
      logic [6:0] duty_applied;
      logic [6:0] pref_applied;
      logic [6:0] dyn_amplitude;
      logic moire_arch_select;
      logic ew_freq_tracking;
      logic dyn_correction_polarity;
      logic charge_pump_select;
      logic moire_route_mode;
      logic loop_inhibit;
      logic vsource_select;
      logic vertical_output_enable;
      logic soft_start;
      logic power_drive_start;
      logic [3:0] test_bits;
   } dcs_ctl_t;

   typedef struct packed {
      dcs_ana_t a1;
      dcs_ana_t a2;
      dcs_ana_t a3;
      logic scl1;
      logic scl2;
      logic scl3;
      logic sda1;
      logic sda2;
      logic sda3;
      dcs_fsm_t fsm;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic rd;
      logic nak;
      logic sub_ok;
      logic [7:0] sub;
      logic sda_oe;
      dcs_regs_t regs;
      logic [7:0] status;
      logic drv_en_d;
      logic blank;
      logic line_out;
      logic power_out;
      logic lock_blank;
      dcs_ctl_t ctl;
   } dcs_st_t;
endpackage

//--- logic/dcs_ctrl.sv
// Serial-bus switch bank and status flags of the deflection controller
//
// Contract
// - Duty data applies at ack, or at vertical discharge when its sync switch is set.
// - Power reference data follows its own sync switch the same way.
// - Moire architecture bit is passed on to the moire circuit.
// - Power drive starts after flyback, or on chosen line-drive edge.
// - Tracking bit makes east-west corrections follow horizontal frequency.
// - Polarity bit picks concave or convex correction parabola.
// - Lock enable adds horizontal lock status to the blanking pin.
// - Loop inhibit enable blocks the phase loop during extracted vertical sync.
// - Charge pump bit selects slow low current or fast high current.
// - Moire mode routes moire to line drive or to its own pin.
// - Writing one clears the three detect flags at ack; bit self-clears.
// - Writing one clears the overvoltage alarm at ack; bit self-clears.
// - Auto mode picks vertical source by detection, keeping the first one.
// - Blank pulse runs from vertical sync to discharge end, or stays high.
// - Vertical output enable gates the vertical ramp output.
// - Drive enable gates line and power drive; rising starts soft start.
// - Detect flags latch on the first pulse until cleared.
// - Polarity flags read zero positive, one negative.
// - Overvoltage event sets alarm and inhibits line drive until cleared.
// - Status byte carries the flags in fixed bit order, locks active low.
// - Outside normal supply line and power drive outputs are inhibited, no ack, registers reset.
// - Addressed registers are write only; status is read only.
// - Any read returns the status byte.
// - Slave at 8C/8D with auto increment and repeated start.
`timescale 1ns/1ps
`include "dcs_defs.svh"

module dcs_ctrl
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Serial bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // Analog-side indications
   input wire dcs_ana_t i_ana,
   // Drives and controls
   output logic o_line_drive_out,
   output logic o_power_drive_out,
   output logic o_lock_blank_pin,
   output dcs_ctl_t o_ctl,
   output logic [7:0] o_status
);

   dcs_st_t st_r;
   dcs_st_t st_nxt;

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic v_seen;
   logic c_seen;
   logic x_seen;
   logic disch_rise;
   logic disch_fall;
   logic fly_fall;
   logic hd_rise;
   logic hd_fall;
   logic det_clr;
   logic alm_clr;
   logic vsync_edge;

   assign scl_rise = st_r.scl2 & ~st_r.scl3;
   assign scl_fall = ~st_r.scl2 & st_r.scl3;
   assign bus_start = st_r.scl2 & st_r.scl3 & st_r.sda3 & ~st_r.sda2;
   assign bus_stop = st_r.scl2 & st_r.scl3 & ~st_r.sda3 & st_r.sda2;
   assign v_seen = st_r.a2.vsync & ~st_r.a3.vsync;
   assign c_seen = st_r.a2.csync & ~st_r.a3.csync;
   assign x_seen = st_r.a2.extr & ~st_r.a3.extr;
   assign disch_rise = st_r.a2.vdisch & ~st_r.a3.vdisch;
   assign disch_fall = ~st_r.a2.vdisch & st_r.a3.vdisch;
   assign fly_fall = ~st_r.a2.flyback & st_r.a3.flyback;
   assign hd_rise = st_r.a2.hdrive & ~st_r.a3.hdrive;
   assign hd_fall = ~st_r.a2.hdrive & st_r.a3.hdrive;

   always_comb begin
      st_nxt = st_r;
      det_clr = 1'b0;
      alm_clr = 1'b0;
      // Two-stage synchronisers, third stage for edges
      st_nxt.a1 = i_ana;
      st_nxt.a2 = st_r.a1;
      st_nxt.a3 = st_r.a2;
      st_nxt.scl1 = i_scl;
      st_nxt.scl2 = st_r.scl1;
      st_nxt.scl3 = st_r.scl2;
      st_nxt.sda1 = i_sda;
      st_nxt.sda2 = st_r.sda1;
      st_nxt.sda3 = st_r.sda2;

      // Serial slave
      if (bus_stop) begin
         st_nxt.fsm = S_IDLE;
         st_nxt.sda_oe = 1'b0;
      end else if (bus_start) begin
         // Repeated start lands here too; subaddress is re-sent
         st_nxt.fsm = S_ADDR;
         st_nxt.cnt = 4'h0;
         st_nxt.sub_ok = 1'b0;
         st_nxt.sda_oe = 1'b0;
      end else begin
         case (st_r.fsm)
            S_IDLE: begin
               st_nxt.sda_oe = 1'b0;
            end
            S_ADDR: begin
               if (scl_rise) begin
                  st_nxt.sh = {st_r.sh[6:0], st_r.sda2};
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end else if (scl_fall && st_r.cnt == `DCS_BIT_LAST) begin
                  if (st_r.sh == `DCS_WR_ADDR || st_r.sh == `DCS_RD_ADDR) begin
                     st_nxt.fsm = S_AACK;
                     st_nxt.sda_oe = 1'b1;
                     st_nxt.rd = st_r.sh[0];
                  end else begin
                     st_nxt.fsm = S_IDLE;
                  end
               end
            end
            S_AACK: begin
               if (scl_fall) begin
                  st_nxt.cnt = 4'h0;
                  if (st_r.rd) begin
                     // Read never looks at the subaddress
                     st_nxt.fsm = S_RD;
                     st_nxt.sh = st_r.status;
                     st_nxt.sda_oe = ~st_r.status[7];
                     st_nxt.cnt = 4'h1;
                  end else begin
                     st_nxt.fsm = S_WR;
                     st_nxt.sda_oe = 1'b0;
                  end
               end
            end
            S_WR: begin
               if (scl_rise) begin
                  st_nxt.sh = {st_r.sh[6:0], st_r.sda2};
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end else if (scl_fall && st_r.cnt == `DCS_BIT_LAST) begin
                  st_nxt.fsm = S_WACK;
                  st_nxt.sda_oe = 1'b1;
                  if (!st_r.sub_ok) begin
                     st_nxt.sub = st_r.sh;
                     st_nxt.sub_ok = 1'b1;
                  end else begin
                     // Write takes effect at the ack bit
                     st_nxt.sub = st_r.sub + 8'h01;
                     case (st_r.sub)
                        `DCS_SAD_DUTY: begin
                           st_nxt.regs.duty = st_r.sh;
                           if (!st_r.sh[`DCS_B_HI]) begin
                              st_nxt.ctl.duty_applied = st_r.sh[6:0];
                           end
                        end
                        `DCS_SAD_MOIRE: st_nxt.regs.moire = st_r.sh;
                        `DCS_SAD_PREF: begin
                           st_nxt.regs.pref = st_r.sh;
                           if (!st_r.sh[`DCS_B_HI]) begin
                              st_nxt.ctl.pref_applied = st_r.sh[6:0];
                           end
                        end
                        `DCS_SAD_PDRV: st_nxt.regs.pdrv = st_r.sh;
                        `DCS_SAD_EW: st_nxt.regs.ew = st_r.sh;
                        `DCS_SAD_DYN: st_nxt.regs.dyn = st_r.sh;
                        `DCS_SAD_LOOP: begin
                           st_nxt.regs.loop = st_r.sh;
                           st_nxt.regs.loop[`DCS_B_DETCLR] = 1'b0;
                           st_nxt.regs.loop[`DCS_B_ALMCLR] = 1'b0;
                           det_clr = st_r.sh[`DCS_B_DETCLR];
                           alm_clr = st_r.sh[`DCS_B_ALMCLR];
                        end
                        `DCS_SAD_OUT: st_nxt.regs.outc = st_r.sh;
                        default: begin
                        end
                     endcase
                  end
               end
            end
            S_WACK: begin
               if (scl_fall) begin
                  st_nxt.fsm = S_WR;
                  st_nxt.sda_oe = 1'b0;
                  st_nxt.cnt = 4'h0;
               end
            end
            S_RD: begin
               if (scl_fall) begin
                  if (st_r.cnt == `DCS_BIT_LAST) begin
                     st_nxt.fsm = S_RACK;
                     st_nxt.sda_oe = 1'b0;
                  end else begin
                     st_nxt.sda_oe = ~st_r.sh[6];
                     st_nxt.sh = {st_r.sh[6:0], 1'b0};
                     st_nxt.cnt = st_r.cnt + 4'h1;
                  end
               end
            end
            S_RACK: begin
               if (scl_rise) begin
                  st_nxt.nak = st_r.sda2;
               end else if (scl_fall) begin
                  if (st_r.nak) begin
                     st_nxt.fsm = S_IDLE;
                  end else begin
                     st_nxt.fsm = S_RD;
                     st_nxt.sh = st_r.status;
                     st_nxt.sda_oe = ~st_r.status[7];
                     st_nxt.cnt = 4'h1;
                  end
               end
            end
            default: begin
               st_nxt.fsm = S_IDLE;
               st_nxt.sda_oe = 1'b0;
            end
         endcase
      end

      // Buffered data applied in step with vertical discharge
      if (disch_rise && st_r.regs.duty[`DCS_B_HI]) begin
         st_nxt.ctl.duty_applied = st_r.regs.duty[6:0];
      end
      if (disch_rise && st_r.regs.pref[`DCS_B_HI]) begin
         st_nxt.ctl.pref_applied = st_r.regs.pref[6:0];
      end

      // Status flags; a new event wins over a clear
      st_nxt.status[0] = (st_r.status[0] & ~det_clr) | v_seen;
      st_nxt.status[1] = (st_r.status[1] & ~det_clr) | c_seen;
      st_nxt.status[2] = (st_r.status[2] & ~det_clr) | x_seen;
      st_nxt.status[3] = st_r.a2.vertical_input_polarity;
      st_nxt.status[4] = st_r.a2.cpol;
      st_nxt.status[5] = (st_r.status[5] & ~alm_clr) | st_r.a2.overvoltage_in;
      st_nxt.status[6] = st_r.a2.vertical_amplitude_locked_n_n;
      st_nxt.status[7] = st_r.a2.horizontal_loop_locked_n_n;

      // Vertical source selection
      if (st_r.regs.loop[`DCS_B_VAUTO]) begin
         if (st_r.status[0] && !st_r.status[2]) begin
            st_nxt.ctl.vsource_select = 1'b1;
         end else if (st_r.status[2] && !st_r.status[0]) begin
            st_nxt.ctl.vsource_select = 1'b0;
         end
      end else begin
         st_nxt.ctl.vsource_select = st_r.regs.loop[`DCS_B_VSEL];
      end

      // Blanking and lock/blank pin
      vsync_edge = st_r.ctl.vsource_select ? v_seen : x_seen;
      if (st_r.regs.outc[`DCS_B_BLANK]) begin
         st_nxt.blank = 1'b1;
      end else if (vsync_edge) begin
         st_nxt.blank = 1'b1;
      end else if (disch_fall) begin
         st_nxt.blank = 1'b0;
      end
      st_nxt.lock_blank = st_r.blank |
         (st_r.regs.loop[`DCS_B_LOCKEN] & st_r.a2.horizontal_loop_locked_n_n);

      // Drive outputs; off levels are line high, power low
      st_nxt.drv_en_d = st_r.regs.outc[`DCS_B_DRVEN];
      st_nxt.ctl.soft_start = st_r.regs.outc[`DCS_B_DRVEN] & ~st_r.drv_en_d;
      st_nxt.line_out = ~st_r.regs.outc[`DCS_B_DRVEN] | st_r.status[5] |
         ~st_r.a2.supply_ok | st_r.a2.hdrive;
      st_nxt.power_out = st_r.regs.outc[`DCS_B_DRVEN] & st_r.a2.supply_ok &
         st_r.a2.bdrive;
      if (!st_r.regs.pdrv[`DCS_B_HI]) begin
         st_nxt.ctl.power_drive_start = st_r.regs.outc[`DCS_B_DRVEN] & fly_fall;
      end else begin
         st_nxt.ctl.power_drive_start = st_r.regs.outc[`DCS_B_DRVEN] &
            (st_r.regs.outc[`DCS_B_EDGE] ? hd_rise : hd_fall);
      end

      // Plain switch outputs
      st_nxt.ctl.moire_arch_select = st_r.regs.moire[`DCS_B_HI];
      st_nxt.ctl.ew_freq_tracking = st_r.regs.ew[`DCS_B_HI];
      st_nxt.ctl.dyn_correction_polarity = st_r.regs.dyn[`DCS_B_HI];
      st_nxt.ctl.dyn_amplitude = st_r.regs.dyn[6:0];
      st_nxt.ctl.charge_pump_select = st_r.regs.loop[`DCS_B_PUMP];
      st_nxt.ctl.moire_route_mode = st_r.regs.loop[`DCS_B_MOIMODE];
      st_nxt.ctl.loop_inhibit = st_r.regs.loop[`DCS_B_INHEN] & st_r.a2.extr;
      st_nxt.ctl.vertical_output_enable = st_r.regs.outc[`DCS_B_VERTICAL_OUTPUT_ENABLE] &
         st_r.a2.supply_ok;
      st_nxt.ctl.test_bits = st_r.regs.outc[7:`DCS_B_TEST_LO];

      // Outside normal supply: registers to default, bus silent
      if (!st_r.a2.supply_ok) begin
         st_nxt.fsm = S_IDLE;
         st_nxt.sda_oe = 1'b0;
         st_nxt.sub_ok = 1'b0;
         st_nxt.regs = {8{`DCS_REG_RST}};
         st_nxt.ctl.duty_applied = 7'h00;
         st_nxt.ctl.pref_applied = 7'h00;
         st_nxt.status[5] = 1'b0;
         st_nxt.ctl.soft_start = 1'b0;
         st_nxt.ctl.power_drive_start = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
         st_r.fsm <= S_IDLE;
         st_r.scl1 <= 1'b1;
         st_r.scl2 <= 1'b1;
         st_r.scl3 <= 1'b1;
         st_r.sda1 <= 1'b1;
         st_r.sda2 <= 1'b1;
         st_r.sda3 <= 1'b1;
         st_r.line_out <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sda_o = 1'b0;
   assign o_sda_oe = st_r.sda_oe;
   assign o_line_drive_out = st_r.line_out;
   assign o_power_drive_out = st_r.power_out;
   assign o_lock_blank_pin = st_r.lock_blank;
   assign o_ctl = st_r.ctl;
   assign o_status = st_r.status;

endmodule

//--- dv/dcs_ctrl_props.sv
// Concurrent checks on the ports of the deflection switch bank
`timescale 1ns/1ps
module dcs_ctrl_props
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Serial bus
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_o,
   input wire logic o_sda_oe,
   // Analog side and outputs
   input wire dcs_ana_t i_ana,
   input wire logic o_line_drive_out,
   input wire logic o_power_drive_out,
   input wire logic o_lock_blank_pin,
   input wire dcs_ctl_t o_ctl,
   input wire logic [7:0] o_status
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   supply_off_a: assert property (!i_ana.supply_ok [*5] |=> o_line_drive_out && !o_power_drive_out)
      else $error("drives not inhibited without supply");
   no_ack_a: assert property (!i_ana.supply_ok [*5] |=> !o_sda_oe)
      else $error("bus answered without supply");
   alarm_set_a: assert property ((i_ana.overvoltage_in && i_ana.supply_ok) [*5] |=> o_line_drive_out && o_status[5])
      else $error("overvoltage did not raise alarm and inhibit");
   pol_live_a: assert property (($stable(i_ana.vertical_input_polarity) && $stable(i_ana.cpol)) [*5]
      |=> o_status[4:3] == {$past(i_ana.cpol), $past(i_ana.vertical_input_polarity)}) else $error("polarity flags wrong");
   lock_live_a: assert property (($stable(i_ana.vertical_amplitude_locked_n_n) && $stable(i_ana.horizontal_loop_locked_n_n)) [*5]
      |=> o_status[7:6] == {$past(i_ana.horizontal_loop_locked_n_n), $past(i_ana.vertical_amplitude_locked_n_n)}) else $error("lock flags wrong");
   det_clear_a: assert property ($fell(o_status[0]) || $fell(o_status[1]) || $fell(o_status[2])
      |-> o_sda_oe || $past(o_sda_oe) || !$past(i_ana.supply_ok, 2) || !$past(i_ana.supply_ok, 3))
      else $error("detect flag dropped outside an acknowledge");
   alarm_clear_a: assert property ($fell(o_status[5])
      |-> o_sda_oe || $past(o_sda_oe) || !$past(i_ana.supply_ok, 2) || !$past(i_ana.supply_ok, 3))
      else $error("alarm dropped outside an acknowledge");
   inhibit_src_a: assert property (o_ctl.loop_inhibit
      |-> $past(i_ana.extr, 2) || $past(i_ana.extr, 3) || $past(i_ana.extr, 4)) else $error("inhibit without pulse");
   no_inhibit_a: assert property (!i_ana.extr [*5] |=> !o_ctl.loop_inhibit)
      else $error("inhibit held without pulse");
   soft_pulse_a: assert property (o_ctl.soft_start |=> !o_ctl.soft_start)
      else $error("soft start longer than one cycle");
   power_start_a: assert property (o_ctl.power_drive_start
      |-> ($past(i_ana.flyback, 4) && !$past(i_ana.flyback, 3)) || ($past(i_ana.hdrive, 4) != $past(i_ana.hdrive, 3)))
      else $error("power drive start without a timing edge");
endmodule

bind dcs_ctrl dcs_ctrl_props chk_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_ana(i_ana), .o_line_drive_out(o_line_drive_out),
   .o_power_drive_out(o_power_drive_out), .o_lock_blank_pin(o_lock_blank_pin), .o_ctl(o_ctl),
   .o_status(o_status));

//--- dv/dcs_host.sv
// Serial bus master model standing in for the host controller
`timescale 1ns/1ps
module dcs_host (
   // Wire level seen by the host
   input wire logic i_sda,
   // Host drives
   output logic o_scl,
   output logic o_sda_pull
);
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end
   // One bit: data set mid-low, clock high 100 ns
   task automatic put(input logic b);
      #50 o_sda_pull = !b;
      #50 o_scl = 1'b1;
      #100 o_scl = 1'b0;
   endtask
   // Start or repeated start, leaves the clock low
   task automatic start();
      #50 o_sda_pull = 1'b0;
      #50 o_scl = 1'b1;
      #50 o_sda_pull = 1'b1;
      #50 o_scl = 1'b0;
   endtask
   task automatic stop();
      #50 o_sda_pull = 1'b1;
      #50 o_scl = 1'b1;
      #50 o_sda_pull = 1'b0;
      #100;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) put(d[i]);
      #50 o_sda_pull = 1'b0;
      #50 o_scl = 1'b1;
      #50 ack = !i_sda;
      #50 o_scl = 1'b0;
   endtask
   // Byte in, then acknowledge or refuse with last
   task automatic recv(input logic last, output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         #50 o_sda_pull = 1'b0;
         #50 o_scl = 1'b1;
         #50 d = {d[6:0], i_sda};
         #50 o_scl = 1'b0;
      end
      put(last);
   endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench of the deflection switch bank
`timescale 1ns/1ps
`include "dcs_defs.svh"
module tb_top;
   import dcs_pkg::*;
   localparam int P_VS = 11;
   localparam int P_CS = 10;
   localparam int P_EX = 9;
   localparam int P_VD = 3;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   dcs_ana_t ana = 13'h1001;
   logic scl, pull, sda_oe, sda_o, sda_line, line_out, power_out, lock_pin, ok;
   dcs_ctl_t ctl;
   logic [7:0] status, r, d15, d16, d17, v, w, b, s;
   int fails = 0;
   int comparisons = 0;
   always #12.5 i_ref_clk = !i_ref_clk;
   assign sda_line = !(pull || (sda_oe && !sda_o));
   dcs_host host_u (.i_sda(sda_line), .o_scl(scl), .o_sda_pull(pull));
   dcs_ctrl dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .i_ana(ana), .o_line_drive_out(line_out), .o_power_drive_out(power_out),
      .o_lock_blank_pin(lock_pin), .o_ctl(ctl), .o_status(status));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic done(input int n);
      $display("test %0d finished", n);
   endtask
   task automatic set(input dcs_ana_t a);
      @(posedge i_ref_clk);
      ana <= a;
      repeat (8) @(posedge i_ref_clk);
   endtask
   task automatic pulse(input int pos);
      dcs_ana_t a;
      a = ana;
      a[pos] = 1'b1;
      set(a);
      a[pos] = 1'b0;
      set(a);
   endtask
   // Bus phases sit 7 ns after the rising clock edges
   task automatic wr(input logic [7:0] sub, d0, d1, d2, input int n);
      logic a;
      logic [7:0] d [3];
      d = '{d0, d1, d2};
      @(posedge i_ref_clk);
      #7;
      host_u.start();
      host_u.send(`DCS_WR_ADDR, ok);
      host_u.send(sub, a);
      for (int i = 0; i < n; i++) host_u.send(d[i], a);
      host_u.stop();
      repeat (4) @(posedge i_ref_clk);
   endtask
   task automatic rd(output logic [7:0] q);
      logic a;
      @(posedge i_ref_clk);
      #7;
      host_u.start();
      host_u.send(`DCS_RD_ADDR, a);
      host_u.recv(1'b1, q);
      host_u.stop();
   endtask
   function automatic logic [7:0] exp_st(input logic [2:0] det, input logic alarm);
      return {ana.horizontal_loop_locked_n_n, ana.vertical_amplitude_locked_n_n, alarm, ana.cpol, ana.vertical_input_polarity, det};
   endfunction
   function automatic logic [7:0] applied(input logic [7:0] sub);
      return {1'b0, (sub == `DCS_SAD_PREF) ? ctl.pref_applied : ctl.duty_applied};
   endfunction
   initial begin
      repeat (100000) @(posedge i_ref_clk);
      fails++;
      report_and_stop();
   end
   initial begin
      dcs_ana_t a;
      r = $urandom(32'hA03D);
      repeat (12) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      r = $urandom;
      set({1'b1, 3'b000, r[1:0], 1'b0, r[3:2], 4'b0001});
      pulse(P_VS);
      pulse(P_CS);
      pulse(P_EX);
      pulse(P_VD);
      rd(b);
      chk(b, exp_st(3'b111, 1'b0));
      done(1);
      d15 = $urandom;
      d16 = (8'($urandom) & 8'h2D) | 8'h02;
      d17 = (8'($urandom) & 8'h0B) | 8'h04;
      wr(`DCS_SAD_DYN, d15, d16, d17, 3);
      chk1(ok, 1'b1);
      chk({1'b0, ctl.dyn_amplitude}, {1'b0, d15[6:0]});
      chk1(ctl.dyn_correction_polarity, d15[7]);
      chk1(ctl.charge_pump_select, d16[2]);
      chk1(ctl.moire_route_mode, d16[3]);
      chk1(ctl.vsource_select, d16[5]);
      chk1(ctl.vertical_output_enable, d17[1]);
      chk({4'h0, ctl.test_bits}, 8'h00);
      chk1(line_out, 1'b0);
      chk1(power_out, 1'b1);
      chk1(lock_pin, d17[0] | (d16[0] & ana.horizontal_loop_locked_n_n));
      a = ana;
      a.extr = 1'b1;
      set(a);
      chk1(ctl.loop_inhibit, 1'b1);
      a.extr = 1'b0;
      set(a);
      chk1(ctl.loop_inhibit, 1'b0);
      pulse(P_VD);
      done(2);
      for (int k = 0; k < 2; k++) begin
         s = k ? `DCS_SAD_PREF : `DCS_SAD_DUTY;
         v = 8'($urandom) & 8'h7F;
         w = 8'($urandom) | 8'h80;
         wr(s, v, 8'h00, 8'h00, 1);
         chk(applied(s), v);
         wr(s, w, 8'h00, 8'h00, 1);
         chk(applied(s), v);
         pulse(P_VD);
         chk(applied(s), {1'b0, w[6:0]});
      end
      r = $urandom;
      wr(`DCS_SAD_MOIRE, r, 8'h00, 8'h00, 1);
      chk1(ctl.moire_arch_select, r[7]);
      wr(`DCS_SAD_PDRV, r, 8'h80, 8'h00, 2);
      chk1(ctl.ew_freq_tracking, 1'b1);
      pulse(2);
      pulse(1);
      done(3);
      wr(`DCS_SAD_LOOP, 8'h52, 8'h00, 8'h00, 1);
      rd(b);
      chk(b, exp_st(3'b000, 1'b0));
      pulse(P_VS);
      chk1(ctl.vsource_select, 1'b1);
      wr(`DCS_SAD_LOOP, 8'h52, 8'h00, 8'h00, 1);
      pulse(P_EX);
      chk1(ctl.vsource_select, 1'b0);
      pulse(P_VS);
      chk1(ctl.vsource_select, 1'b0);
      repeat (16) @(posedge i_ref_clk);
      rd(b);
      chk(b, exp_st(3'b101, 1'b0));
      done(4);
      a = ana;
      a.overvoltage_in = 1'b1;
      set(a);
      chk1(line_out, 1'b1);
      a.overvoltage_in = 1'b0;
      set(a);
      rd(b);
      chk(b, exp_st(3'b101, 1'b1));
      chk1(line_out, 1'b1);
      wr(`DCS_SAD_LOOP, 8'h82, 8'h00, 8'h00, 1);
      rd(b);
      chk(b, exp_st(3'b101, 1'b0));
      chk1(line_out, 1'b0);
      done(5);
      @(posedge i_ref_clk);
      #7;
      host_u.start();
      host_u.send(8'h5A, ok);
      host_u.stop();
      chk1(ok, 1'b0);
      r = $urandom;
      wr(8'h14, 8'hFF, r, 8'h00, 2);
      chk({1'b0, ctl.dyn_amplitude}, {1'b0, r[6:0]});
      done(6);
      a = ana;
      a.supply_ok = 1'b0;
      set(a);
      chk1(line_out, 1'b1);
      chk1(power_out, 1'b0);
      wr(`DCS_SAD_EW, 8'h80, 8'h00, 8'h00, 1);
      chk1(ok, 1'b0);
      a.supply_ok = 1'b1;
      set(a);
      chk({1'b0, ctl.dyn_amplitude}, 8'h00);
      chk1(ctl.ew_freq_tracking, 1'b0);
      done(7);
      report_and_stop();
   end
endmodule
